// [hw/placed_pulse_width_modulator.sv]
// per-clock placed pulse width modulator with sub-step output
`include "pwm_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module placed_pulse_width_modulator (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     period_strobe,
    input  wire logic [`PWM_CODE_W-1:0]   width_code,
    input  wire logic                     one_or_two_edge_sel,
    input  wire logic                     early_late_edge_sel,
    input  wire logic                     force_high,
    input  wire logic                     cal_start,
    input  wire logic                     sleep_n,
    input  wire logic [`PWM_TRIM_W-1:0]   trim_target,
    output logic                          pwm_out,
    output logic                          cal_done,
    output logic [`PWM_TRIM_W-1:0]        trim
);
    // period_strobe marks the video clock edge; sys_clk paces sub-steps
    typedef struct packed {
        logic [1:0]                  strobe_sync;
        logic                        strobe_seen;
        logic [1:0]                  force_sync;
        logic [1:0]                  sleep_sync;
        logic [1:0]                  cal_sync;
        // data pins get the same two flops as the strobe, so they stay aligned
        logic [1:0][`PWM_CODE_W-1:0] code_sync;
        logic [1:0]                  one_two_sync;
        logic [1:0]                  early_late_sync;
        logic [1:0][`PWM_TRIM_W-1:0] target_sync;
        logic [`PWM_CODE_W-1:0]      cap_code;
        pwm_pkg::place_mode_t        cap_mode;
        logic [`PWM_CODE_W-1:0]      run_code;
        pwm_pkg::place_mode_t        run_mode;
        logic [`PWM_CODE_W-1:0]      sub;
        logic                        out;
    } pwm_reg_t;

    pwm_reg_t r;
    pwm_reg_t next_r;
    logic     period_edge;
    logic     pulse_on;

    function automatic pwm_pkg::place_mode_t decode_mode(
        input logic one_two,
        input logic early_late
    );
        if (!one_two) begin
            decode_mode = pwm_pkg::MODE_CENTER;
        end else if (early_late) begin
            decode_mode = pwm_pkg::MODE_RIGHT;
        end else begin
            decode_mode = pwm_pkg::MODE_LEFT;
        end
    endfunction

    // sub-step s is high when it falls in the placed window of code steps
    function automatic logic in_window(
        input logic [`PWM_CODE_W-1:0] code,
        input pwm_pkg::place_mode_t   mode,
        input logic [`PWM_CODE_W-1:0] s
    );
        logic [`PWM_CODE_W:0] lo;
        logic [`PWM_CODE_W:0] hi;
        lo = '0;
        hi = '0;
        case (mode)
            pwm_pkg::MODE_LEFT: begin
                lo = '0;
                hi = {1'b0, code};
            end
            pwm_pkg::MODE_RIGHT: begin
                lo = {1'b0, `PWM_CODE_FULL} - {1'b0, code};
                hi = {1'b0, `PWM_CODE_FULL};
            end
            pwm_pkg::MODE_CENTER: begin
                // even codes put the extra step early; odd codes centre on the mid step
                lo = ({1'b0, `PWM_CODE_FULL} - {1'b0, code}) >> 1;
                hi = lo + {1'b0, code};
            end
            default: begin
                lo = '0;
                hi = '0;
            end
        endcase
        in_window = ({1'b0, s} >= lo) && ({1'b0, s} < hi);
    endfunction

    assign period_edge = r.strobe_sync[1] && !r.strobe_seen;

    always_comb begin
        next_r = r;
        next_r.strobe_sync = {r.strobe_sync[0], period_strobe};
        next_r.force_sync  = {r.force_sync[0], force_high};
        next_r.sleep_sync  = {r.sleep_sync[0], sleep_n};
        next_r.cal_sync    = {r.cal_sync[0], cal_start};
        next_r.code_sync   = {r.code_sync[0], width_code};
        next_r.one_two_sync = {r.one_two_sync[0], one_or_two_edge_sel};
        next_r.early_late_sync = {r.early_late_sync[0], early_late_edge_sel};
        next_r.target_sync = {r.target_sync[0], trim_target};
        next_r.strobe_seen = r.strobe_sync[1];
        if (period_edge) begin
            // first stage captures, second feeds the running period
            next_r.cap_code = r.code_sync[1];
            next_r.cap_mode = decode_mode(r.one_two_sync[1],
                                          r.early_late_sync[1]);
            next_r.run_code = r.cap_code;
            next_r.run_mode = r.cap_mode;
            next_r.sub      = `PWM_SUB_FIRST;
        end else if (r.sub != `PWM_SUB_LAST) begin
            next_r.sub = r.sub + `PWM_CODE_W'(1);
        end
        next_r.out = pulse_on;
    end

    always_comb begin
        if (r.force_sync[1]) begin
            pulse_on = 1'b1;
        end else if (!r.sleep_sync[1]) begin
            pulse_on = 1'b0;
        end else if (r.run_code == `PWM_CODE_FULL) begin
            pulse_on = 1'b1;
        end else if (r.run_code == `PWM_CODE_ZERO) begin
            pulse_on = 1'b0;
        end else begin
            pulse_on = in_window(r.run_code, r.run_mode, r.sub);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pwm_out = r.out;

    pwm_calibrator u_cal (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .cal_start   (r.cal_sync[1]),
        .awake       (r.sleep_sync[1]),
        .trim_target (r.target_sync[1]),
        .cal_done    (cal_done),
        .trim        (trim)
    );

    sequence full_run;
        r.sleep_sync[1] && !r.force_sync[1] && r.run_code == `PWM_CODE_FULL;
    endsequence

    // awake and not forced: only the placed window decides the output
    sequence window_run;
        r.sleep_sync[1] && !r.force_sync[1];
    endsequence

    AST_FULL_HIGH: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        full_run |=> r.out)
        else $error("code 255 did not drive high");
    AST_ZERO_LOW: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!r.force_sync[1] && r.run_code == `PWM_CODE_ZERO) |=> !r.out)
        else $error("code 0 did not hold low");
    AST_FORCE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.force_sync[1] |=> r.out)
        else $error("force high ignored");
    AST_PIPE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        period_edge |=> (r.run_code == $past(r.cap_code)))
        else $error("second stage did not take first stage");
    AST_CAPTURE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        period_edge |=> (r.cap_code == $past(r.code_sync[1])))
        else $error("first stage did not take the code");
    AST_LEFT_START: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (period_edge && r.cap_mode == pwm_pkg::MODE_LEFT &&
         r.cap_code != `PWM_CODE_ZERO) |=> (r.sleep_sync[1] |=> r.out))
        else $error("left mode did not rise at period start");
    AST_LEFT_FALL: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (window_run ##0 (r.run_mode == pwm_pkg::MODE_LEFT &&
         r.run_code != `PWM_CODE_FULL && r.sub >= r.run_code)) |=> !r.out)
        else $error("left mode high past its code");
    AST_RIGHT_END: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (r.sleep_sync[1] && r.run_mode == pwm_pkg::MODE_RIGHT &&
         r.run_code != `PWM_CODE_ZERO && r.sub == `PWM_SUB_LAST) |=> r.out)
        else $error("right mode not high at period end");
    AST_RIGHT_LATE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (window_run ##0 (r.run_mode == pwm_pkg::MODE_RIGHT &&
         r.run_code != `PWM_CODE_FULL &&
         ({1'b0, r.sub} + {1'b0, r.run_code}) < {1'b0, `PWM_CODE_FULL}))
        |=> !r.out)
        else $error("right mode rose too early");
    AST_CENTER_MID: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (window_run ##0 (r.run_mode == pwm_pkg::MODE_CENTER &&
         r.run_code != `PWM_CODE_ZERO && r.sub == `PWM_SUB_MID)) |=> r.out)
        else $error("centred pulse missed the mid point");
    AST_SUB_HOLD: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!period_edge && r.sub == `PWM_SUB_LAST) |=> (r.sub == `PWM_SUB_LAST))
        else $error("sub-step ran past the last step");
    AST_MODE_DECODE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (period_edge && !r.one_two_sync[1]) |=>
        r.cap_mode == pwm_pkg::MODE_CENTER)
        else $error("centred mode decode wrong");
    AST_SLEEP_OFF: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!r.sleep_sync[1] && !r.force_sync[1]) |=> !r.out)
        else $error("output active while asleep");
endmodule
`default_nettype wire

// [hw/pwm_calibrator.sv]
// trim stepping sequencer started by the falling edge of the start pulse
`include "pwm_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module pwm_calibrator (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     cal_start,
    input  wire logic                     awake,
    input  wire logic [`PWM_TRIM_W-1:0]   trim_target,
    output logic                          cal_done,
    output logic [`PWM_TRIM_W-1:0]        trim
);
    typedef struct packed {
        pwm_pkg::cal_state_t          state;
        logic [`PWM_CAL_DIV_W-1:0]    div;
        logic [`PWM_TRIM_W-1:0]       trim;
        logic                         done;
    } cal_reg_t;

    cal_reg_t r;
    cal_reg_t next_r;

    always_comb begin
        next_r = r;
        // sleep loses calibration; cleared first so a finishing step wins
        if (!awake) begin
            next_r.done = 1'b0;
        end
        case (r.state)
            pwm_pkg::CAL_IDLE, pwm_pkg::CAL_DONE: begin
                if (cal_start) begin
                    next_r.state = pwm_pkg::CAL_ARMED;
                end
            end
            pwm_pkg::CAL_ARMED: begin
                // trim held slowest until start falls
                next_r.trim = `PWM_TRIM_ZERO;
                next_r.div  = `PWM_CAL_DIV_W'(0);
                next_r.done = 1'b0;
                if (!cal_start) begin
                    next_r.state = pwm_pkg::CAL_STEP;
                end
            end
            pwm_pkg::CAL_STEP: begin
                next_r.div = r.div + `PWM_CAL_DIV_W'(1);
                if (r.trim >= trim_target || r.trim == `PWM_TRIM_MAX) begin
                    next_r.done  = 1'b1;
                    next_r.state = pwm_pkg::CAL_DONE;
                end else if (r.div == `PWM_CAL_DIV) begin
                    next_r.trim = r.trim + `PWM_TRIM_W'(1);
                end
            end
            default: next_r.state = pwm_pkg::CAL_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign cal_done = r.done;
    assign trim     = r.trim;

    AST_TRIM_STEP_SPACING: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (r.state == pwm_pkg::CAL_STEP && r.div != `PWM_CAL_DIV &&
         !next_r.done) |=> $stable(r.trim))
        else $error("trim stepped off the 32-clock boundary");
    AST_TRIM_BOUND: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.trim <= `PWM_TRIM_MAX)
        else $error("trim exceeded 64 steps");
endmodule
`default_nettype wire

// [hw/pwm_defines.svh]
// constants of the placed pulse width modulator
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH
`define PWM_CODE_W      8
`define PWM_CODE_ZERO   8'h00
`define PWM_CODE_FULL   8'hFF
`define PWM_SUB_LAST    8'hFE
`define PWM_SUB_FIRST   8'h00
`define PWM_SUB_MID     8'h7F
`define PWM_CAL_DIV     5'h1F
`define PWM_CAL_DIV_W   5
`define PWM_TRIM_W      7
`define PWM_TRIM_MAX    7'h40
`define PWM_TRIM_ZERO   7'h00
`define PWM_TRIM_TARGET_DEF 7'h20
`endif

// [hw/pwm_pkg.sv]
// types of the placed pulse width modulator
`default_nettype none
package pwm_pkg;
    typedef enum logic [1:0] {
        MODE_RIGHT,
        MODE_LEFT,
        MODE_CENTER
    } place_mode_t;

    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_ARMED,
        CAL_STEP,
        CAL_DONE
    } cal_state_t;
endpackage
`default_nettype wire

// [tb/placed_pulse_width_modulator_tb_top.sv]
// self-checking bench of the placed pulse width modulator
`include "pwm_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module placed_pulse_width_modulator_tb_top;
    logic                   sys_clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   enable = 1'b0;
    logic                   force_high = 1'b0;
    logic                   cal_start = 1'b0;
    logic                   sleep_n = 1'b1;
    logic [`PWM_TRIM_W-1:0] trim_target = 7'h05;
    logic [`PWM_CODE_W-1:0] next_code = 8'h00;
    logic                   next_ot = 1'b0;
    logic                   next_el = 1'b0;
    logic [`PWM_CODE_W-1:0] width_code;
    logic                   strobe, ot, el, pwm_out, cal_done;
    logic [`PWM_TRIM_W-1:0] trim;
    logic [9:0]             prev = 10'h000;
    int                     phase, i;
    int                     n_mismatch = 0;
    int                     checks_done = 0;
    // {one_or_two, early_late, code}
    logic [9:0] words [11] = '{10'h0ff, 10'h2ff, 10'h300,
        10'h3c8, 10'h2c8, 10'h101,
        10'h0fe, 10'h380, 10'h27f,
        10'h301, 10'h200};
    always #5 sys_clk = ~sys_clk;
    video_host_model u_host (.sys_clk(sys_clk), .enable(enable),
        .next_code(next_code), .next_one_two(next_ot),
        .next_early_late(next_el), .period_strobe(strobe),
        .width_code(width_code), .one_or_two_edge_sel(ot),
        .early_late_edge_sel(el), .phase(phase));
    placed_pulse_width_modulator u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .period_strobe(strobe), .width_code(width_code),
        .one_or_two_edge_sel(ot), .early_late_edge_sel(el),
        .force_high(force_high), .cal_start(cal_start),
        .sleep_n(sleep_n), .trim_target(trim_target),
        .pwm_out(pwm_out), .cal_done(cal_done), .trim(trim));
    task automatic finish_test;
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick;
        @(posedge sys_clk);
        #2;
    endtask
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %0d seen %0d", what, e, g);
        end
    endtask
    // ovr 1: forced high, ovr 2: asleep; checks the word sent one earlier
    task automatic step(input logic [9:0] w, input bit meas, input int ovr);
        int cnt, first, last, ef, ec, n;
        next_code = w[7:0];
        next_ot = w[9];
        next_el = w[8];
        for (n = 0; n < 600 && phase != 0; n++)
            tick();
        if (n == 600) begin
            n_mismatch++;
            finish_test();
        end
        repeat (4) tick();
        cnt = 0;
        first = -1;
        last = -1;
        for (n = 0; n < 255; n++) begin
            if (pwm_out === 1'b1) begin
                cnt++;
                last = n;
                if (first < 0)
                    first = n;
            end
            tick();
        end
        ec = prev[7:0];
        ef = 0;
        if (ovr == 1)
            ec = 255;
        else if (ovr == 2)
            ec = 0;
        else if (prev[7:0] == 8'hff)
            ec = 255;
        else if (!prev[9])
            ef = (255 - ec) >> 1;
        else if (prev[8])
            ef = 255 - ec;
        if (meas) begin
            chk("pulse_count", ec, cnt);
            if (ec > 0) begin
                chk("pulse_first", ef, first);
                chk("pulse_last", ef + ec - 1, last);
            end
        end
        prev = w;
    endtask
    task automatic calibrate(input logic [6:0] tgt, input logic [6:0] et,
                             input int lo, input int hi);
        int n;
        trim_target = tgt;
        cal_start = 1'b1;
        repeat (8) tick();
        chk("cal_done_armed", 0, cal_done);
        cal_start = 1'b0;
        for (n = 0; n < 2400 && cal_done !== 1'b1; n++)
            tick();
        if (n == 2400) begin
            n_mismatch++;
            finish_test();
        end
        chk("cal_time_in_window", 1, n >= lo && n <= hi);
        chk("trim", et, trim);
    endtask
    initial begin
        repeat (5) tick();
        chk("reset_trim", 0, trim);
        rst_n = 1'b1;
        repeat (3) tick();
        calibrate(7'h05, 7'h05, 150, 175);
        calibrate(7'h7f, 7'h40, 2030, 2070);
        enable = 1'b1;
        for (i = 0; i < 11; i++)
            step(words[i], i > 0, 0);
        force_high = 1'b1;
        step(10'h300, 1, 1);
        force_high = 1'b0;
        step(10'h2ff, 1, 0);
        sleep_n = 1'b0;
        step(10'h000, 1, 2);
        chk("sleep_cal_done", 0, cal_done);
        sleep_n = 1'b1;
        calibrate(7'h05, 7'h05, 150, 175);
        finish_test();
    end
endmodule
`default_nettype wire

// [tb/video_host_model.sv]
// host video controller model: one code word per video period
`include "pwm_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module video_host_model (
    input  wire logic                   sys_clk,
    input  wire logic                   enable,
    input  wire logic [`PWM_CODE_W-1:0] next_code,
    input  wire logic                   next_one_two,
    input  wire logic                   next_early_late,
    output logic                        period_strobe,
    output logic [`PWM_CODE_W-1:0]      width_code,
    output logic                        one_or_two_edge_sel,
    output logic                        early_late_edge_sel,
    output int                          phase
);
    // 260 clocks leave room for 255 sub-steps plus the pipe latency
    localparam int PERIOD = 260;
    initial begin
        period_strobe = 1'b0;
        width_code = 8'h00;
        one_or_two_edge_sel = 1'b0;
        early_late_edge_sel = 1'b0;
        phase = PERIOD - 1;
    end
    always @(posedge sys_clk) begin
        #1;
        phase = !enable ? PERIOD - 1 : (phase == PERIOD - 1) ? 0 : phase + 1;
        period_strobe = enable && phase < 8;
        if (enable && phase == 0) begin
            width_code = next_code;
            one_or_two_edge_sel = next_one_two;
            early_late_edge_sel = next_early_late;
        end
        // past the hold time the lines no longer show the word
        if (phase == 8) begin
            width_code = ~width_code;
            one_or_two_edge_sel = ~one_or_two_edge_sel;
            early_late_edge_sel = ~early_late_edge_sel;
        end
    end
endmodule
`default_nettype wire
